/* File: shared/motion_cw_consts.svh */
// Constants for the motion control word decoder: bit positions and sizes.
// Assumes inclusion by bare name from the design file.
`ifndef MOTION_CW_CONSTS_SVH
`define MOTION_CW_CONSTS_SVH

// ---------------------------------------------------------------
// Control word bit positions
// ---------------------------------------------------------------
`define CW_RESERVED_BIT      15
`define CW_TARGET_POS_BIT    14
`define CW_ZERO_BIT          13
`define CW_DRIVE_CUT_BIT     12
`define CW_STANDSTILL_BIT    11
`define CW_PRESET_BIT        10
`define CW_DECAY_BIT         9
`define CW_ENCODER_BIT       8
`define CW_LAG_BIT           7
`define CW_ADVANCE_BIT       6
`define CW_LATCH_VIEW_BIT    5
`define CW_EXT_FALL_BIT      4
`define CW_EXT_RISE_BIT      3
`define CW_IN_TWO_BIT        2
`define CW_IN_ONE_BIT        1
`define CW_INDEX_BIT         0
`define COMMAND_BYTE_CUT_BIT 3

// ---------------------------------------------------------------
// Sizes and reset values
// ---------------------------------------------------------------
`define CAPTURE_DEPTH        20
`define CW_RESET             16'h0000
`define POSITION_RESET       32'h0000_0000

`endif

/* File: shared/motion_cw_pkg.sv */
// Types for the motion control word decoder.
// Assumes no other package.
package motion_cw_pkg;

    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_INDEX,
        SRC_EXT_FALL,
        SRC_EXT_RISE,
        SRC_IN_ONE,
        SRC_IN_TWO
    } capture_src_t;

    typedef enum logic [1:0] {
        VIEW_POSITION,
        VIEW_LAG,
        VIEW_ENCODER,
        VIEW_LATCH
    } view_t;

    // Raw input pins sampled for latch events
    typedef struct packed {
        logic index_c;
        logic ext_latch;
        logic digital_input_one;
        logic digital_input_two;
    } latch_pins_t;

    // Drive settings handed to the bridge logic
    typedef struct packed {
        logic target_position_select;
        logic reduce_running;
        logic reduce_standstill;
        logic single_pulse_decay_sel;
    } drive_ctl_t;

endpackage

/* File: logic/stepper_control_word_decoder.sv */
// Decoder of the 16-bit motion control word of a stepper terminal.
// Assumes the control word, pins and positions are synchronous to clk.
//
// Overview of operation
// - Bit 14 high: cyclic process value is a target position, not velocity.
// - Rising edge of bit 13 clears the position count to zero.
// - Rising edge of bit 10 loads position from preset pair, only if bit 13 low.
// - Bit 12 high: apply reduced current level even while rotating.
// - Bit 11 high: reduced current at standstill, same as command byte bit 3.
// - Bit 9 low: both transistors pulsed; high: one pulsed, one held on.
// - Bit 8 high: report encoder position, encoder variant with internal positioning.
// - Bit 7 selects position or relative position error in input bytes 2 and 3, with internal positioning only.
// - Bit 5 selects position or latched value in input bytes 2 and 3.
// - Bit 6 change with array enabled and bit 5 set shows next of 20 values.
// - Bit 4 high: capture position on falling external latch edge; beats bits 1,2.
// - Bit 3 high: capture position on rising external latch edge; beats bits 1,2.
// - Bit 2 high: capture position on rising edge of digital input two.
// - Bit 1 high: capture on rising edge of digital input one; beats bit 2.
// - Bit 0 high: capture on rising index edge; beats every other source that is not already armed and still enabled.
`timescale 1ns/100ps
`include "motion_cw_consts.svh"

module stepper_control_word_decoder (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    // Process output image
    input  wire logic [15:0]                 motion_control_word,
    input  wire logic                        command_byte_cut,
    input  wire logic [31:0]                 process_value,
    // Registers of the terminal
    input  wire logic [15:0]                 preset_low_reg,
    input  wire logic [15:0]                 preset_high_reg,
    input  wire logic [7:0]                  reduced_current_level_reg,
    input  wire logic                        capture_array_enable,
    input  wire logic                        encoder_variant,
    input  wire logic                        internal_positioning,
    // Motion sources
    input  wire logic [31:0]                 step_delta,
    input  wire logic                        step_valid,
    input  wire logic [31:0]                 position_error,
    input  wire logic [31:0]                 encoder_position,
    input  wire motion_cw_pkg::latch_pins_t  latch_pins,
    // Drive outputs
    output logic [31:0]                      position,
    output logic [31:0]                      target_position,
    output logic [31:0]                      target_velocity,
    output motion_cw_pkg::drive_ctl_t        drive_ctl,
    output logic [7:0]                       current_limit,
    output logic                             current_limit_en,
    // Process input image
    output logic [15:0]                      input_bytes_2_3,
    output logic [4:0]                       capture_count,
    output logic                             capture_valid,
    output logic                             latch_view_active
);

    // ---------------------------------------------------------------
    // Edge history
    // ---------------------------------------------------------------
    logic [15:0]                     cw_prev;
    logic [15:0]                     next_cw_prev;
    motion_cw_pkg::latch_pins_t      pins_prev;
    motion_cw_pkg::latch_pins_t      next_pins_prev;
    logic [15:0]                     cw;

    always_comb begin
        cw = motion_control_word;
        // Bit 15 forced low so a stray one decodes nothing
        cw[`CW_RESERVED_BIT] = 1'b0;
        next_cw_prev = cw;
        next_pins_prev = latch_pins;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cw_prev   <= `CW_RESET;
            pins_prev <= '0;
        end else begin
            cw_prev   <= next_cw_prev;
            pins_prev <= next_pins_prev;
        end
    end

    // ---------------------------------------------------------------
    // Edge detection
    // ---------------------------------------------------------------
    // History resets low: a bit held high through reset acts as an edge
    logic zero_rise;
    logic preset_rise;
    logic advance_toggle;
    assign zero_rise      = cw[`CW_ZERO_BIT] & ~cw_prev[`CW_ZERO_BIT];
    assign preset_rise    = cw[`CW_PRESET_BIT] & ~cw_prev[`CW_PRESET_BIT];
    assign advance_toggle = cw[`CW_ADVANCE_BIT] ^ cw_prev[`CW_ADVANCE_BIT];

    // ---------------------------------------------------------------
    // Position count
    // ---------------------------------------------------------------
    logic [31:0] next_position;

    always_comb begin
        next_position = position;
        // Clear beats preset, and both beat a step in the same cycle
        if (zero_rise) begin
            next_position = `POSITION_RESET;
        end else if (preset_rise && !cw[`CW_ZERO_BIT]) begin
            next_position = {preset_high_reg, preset_low_reg};
        end else if (step_valid) begin
            next_position = position + step_delta;
        end
    end

    // ---------------------------------------------------------------
    // Drive settings and process value routing
    // ---------------------------------------------------------------
    motion_cw_pkg::drive_ctl_t next_drive_ctl;
    logic [31:0]               next_target_position;
    logic [31:0]               next_target_velocity;
    logic [7:0]                next_current_limit;
    logic                      next_current_limit_en;

    always_comb begin
        next_drive_ctl.target_position_select = cw[`CW_TARGET_POS_BIT];
        next_drive_ctl.reduce_running         = cw[`CW_DRIVE_CUT_BIT];
        // Either source asks for standstill reduction
        next_drive_ctl.reduce_standstill      = cw[`CW_STANDSTILL_BIT] | command_byte_cut;
        next_drive_ctl.single_pulse_decay_sel = cw[`CW_DECAY_BIT];
        // Register not selected keeps its last value
        next_target_position = target_position;
        next_target_velocity = target_velocity;
        if (cw[`CW_TARGET_POS_BIT]) begin
            next_target_position = process_value;
        end else begin
            next_target_velocity = process_value;
        end
        next_current_limit    = reduced_current_level_reg;
        next_current_limit_en = next_drive_ctl.reduce_running | next_drive_ctl.reduce_standstill;
    end

    // ---------------------------------------------------------------
    // Capture source arbitration
    // ---------------------------------------------------------------
    motion_cw_pkg::capture_src_t armed;
    motion_cw_pkg::capture_src_t next_armed;
    motion_cw_pkg::capture_src_t best;

    always_comb begin
        if (cw[`CW_INDEX_BIT]) begin
            best = motion_cw_pkg::SRC_INDEX;
        end else if (cw[`CW_EXT_FALL_BIT]) begin
            best = motion_cw_pkg::SRC_EXT_FALL;
        end else if (cw[`CW_EXT_RISE_BIT]) begin
            best = motion_cw_pkg::SRC_EXT_RISE;
        end else if (cw[`CW_IN_ONE_BIT]) begin
            best = motion_cw_pkg::SRC_IN_ONE;
        end else if (cw[`CW_IN_TWO_BIT]) begin
            best = motion_cw_pkg::SRC_IN_TWO;
        end else begin
            best = motion_cw_pkg::SRC_NONE;
        end
    end

    logic armed_enabled;
    always_comb begin
        case (armed)
            motion_cw_pkg::SRC_INDEX:    armed_enabled = cw[`CW_INDEX_BIT];
            motion_cw_pkg::SRC_EXT_FALL: armed_enabled = cw[`CW_EXT_FALL_BIT];
            motion_cw_pkg::SRC_EXT_RISE: armed_enabled = cw[`CW_EXT_RISE_BIT];
            motion_cw_pkg::SRC_IN_ONE:   armed_enabled = cw[`CW_IN_ONE_BIT];
            motion_cw_pkg::SRC_IN_TWO:   armed_enabled = cw[`CW_IN_TWO_BIT];
            default:                     armed_enabled = 1'b0;
        endcase
        // Hold the armed source until disabled, then take the best one
        next_armed = armed_enabled ? armed : best;
    end

    // ---------------------------------------------------------------
    // Capture event
    // ---------------------------------------------------------------
    logic capture_hit;
    always_comb begin
        case (armed)
            motion_cw_pkg::SRC_INDEX:
                capture_hit = latch_pins.index_c & ~pins_prev.index_c;
            motion_cw_pkg::SRC_EXT_FALL:
                capture_hit = ~latch_pins.ext_latch & pins_prev.ext_latch;
            motion_cw_pkg::SRC_EXT_RISE:
                capture_hit = latch_pins.ext_latch & ~pins_prev.ext_latch;
            motion_cw_pkg::SRC_IN_ONE:
                capture_hit = latch_pins.digital_input_one & ~pins_prev.digital_input_one;
            motion_cw_pkg::SRC_IN_TWO:
                capture_hit = latch_pins.digital_input_two & ~pins_prev.digital_input_two;
            default:
                capture_hit = 1'b0;
        endcase
        capture_hit = capture_hit & armed_enabled;
    end

    // ---------------------------------------------------------------
    // Capture array
    // ---------------------------------------------------------------
    // Without the array only slot 0 is used and each capture overwrites it
    logic [31:0] capture_mem [`CAPTURE_DEPTH];
    logic [31:0] next_capture_mem [`CAPTURE_DEPTH];
    logic [4:0]  wr_ptr;
    logic [4:0]  rd_ptr;
    logic [4:0]  next_wr_ptr;
    logic [4:0]  next_rd_ptr;
    logic [4:0]  next_capture_count;
    logic        next_capture_valid;
    logic        pop;

    always_comb begin
        next_capture_mem   = capture_mem;
        next_wr_ptr        = wr_ptr;
        next_rd_ptr        = rd_ptr;
        next_capture_count = capture_count;
        next_capture_valid = capture_valid;
        // Last entry is kept, so the view never goes stale
        pop = advance_toggle && capture_array_enable && cw[`CW_LATCH_VIEW_BIT]
              && (capture_count > 5'h01);
        if (pop) begin
            next_rd_ptr = (rd_ptr == 5'(`CAPTURE_DEPTH - 1)) ? 5'h00 : rd_ptr + 5'h01;
            next_capture_count = next_capture_count - 5'h01;
        end
        if (capture_hit) begin
            next_capture_valid = 1'b1;
            if (!capture_array_enable) begin
                next_capture_mem[0] = position;
                next_rd_ptr         = 5'h00;
                next_wr_ptr         = 5'h00;
                next_capture_count  = 5'h01;
            end else if (next_capture_count < 5'(`CAPTURE_DEPTH)) begin
                // A full array drops new events instead of losing stored ones
                next_capture_mem[wr_ptr] = position;
                next_wr_ptr = (wr_ptr == 5'(`CAPTURE_DEPTH - 1)) ? 5'h00 : wr_ptr + 5'h01;
                next_capture_count = next_capture_count + 5'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Input image view
    // ---------------------------------------------------------------
    logic [15:0] next_input_bytes;
    logic        next_latch_view_active;
    logic        int_enc;

    always_comb begin
        int_enc = internal_positioning;
        // Reads memory before this cycle's capture lands: one cycle of lag
        next_latch_view_active = cw[`CW_LATCH_VIEW_BIT];
        if (cw[`CW_ENCODER_BIT] && int_enc && encoder_variant) begin
            next_input_bytes = encoder_position[15:0];
        end else if (cw[`CW_LATCH_VIEW_BIT]) begin
            next_input_bytes = capture_mem[rd_ptr][15:0];
        end else if (cw[`CW_LAG_BIT] && int_enc) begin
            next_input_bytes = position_error[15:0];
        end else begin
            next_input_bytes = position[15:0];
        end
    end

    // ---------------------------------------------------------------
    // State registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            position          <= `POSITION_RESET;
            target_position   <= `POSITION_RESET;
            target_velocity   <= `POSITION_RESET;
            drive_ctl         <= '0;
            current_limit     <= 8'h00;
            current_limit_en  <= 1'b0;
            armed             <= motion_cw_pkg::SRC_NONE;
            wr_ptr            <= 5'h00;
            rd_ptr            <= 5'h00;
            capture_count     <= 5'h00;
            capture_valid     <= 1'b0;
            input_bytes_2_3   <= 16'h0000;
            latch_view_active <= 1'b0;
            for (int i = 0; i < `CAPTURE_DEPTH; i++) begin
                capture_mem[i] <= 32'h0000_0000;
            end
        end else begin
            position          <= next_position;
            target_position   <= next_target_position;
            target_velocity   <= next_target_velocity;
            drive_ctl         <= next_drive_ctl;
            current_limit     <= next_current_limit;
            current_limit_en  <= next_current_limit_en;
            armed             <= next_armed;
            wr_ptr            <= next_wr_ptr;
            rd_ptr            <= next_rd_ptr;
            capture_count     <= next_capture_count;
            capture_valid     <= next_capture_valid;
            input_bytes_2_3   <= next_input_bytes;
            latch_view_active <= next_latch_view_active;
            capture_mem       <= next_capture_mem;
        end
    end

endmodule

/* File: bench/stepper_control_word_decoder_props.sv */
// Port checker for the control word decoder, bound into it.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps

module stepper_control_word_decoder_props (
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       rstn,
    // Inputs
    input wire logic [15:0]                motion_control_word,
    input wire logic                       command_byte_cut,
    input wire logic [15:0]                preset_low_reg,
    input wire logic [15:0]                preset_high_reg,
    input wire logic                       capture_array_enable,
    input wire logic                       encoder_variant,
    input wire logic                       internal_positioning,
    input wire logic                       step_valid,
    input wire logic [31:0]                position_error,
    input wire logic [31:0]                encoder_position,
    input wire motion_cw_pkg::latch_pins_t latch_pins,
    // Outputs
    input wire logic [31:0]                position,
    input wire motion_cw_pkg::drive_ctl_t  drive_ctl,
    input wire logic                       current_limit_en,
    input wire logic [15:0]                input_bytes_2_3,
    input wire logic [4:0]                 capture_count
);
    wire [15:0] w = motion_control_word;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_tps; $past(rstn) |-> drive_ctl.target_position_select == $past(w[14]); endproperty
    a_tps: assert property (p_tps) else $error("target select wrong");
    property p_zero; $past(rstn) && $past(w[13]) && !$past(w[13], 2) |-> position == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("position not cleared");
    property p_pre;
        $past(rstn && w[10] && !w[13] && !step_valid) && !$past(w[10], 2)
            |-> position == $past({preset_high_reg, preset_low_reg});
    endproperty
    a_pre: assert property (p_pre) else $error("preset not loaded");
    property p_cut; $past(rstn) |-> current_limit_en == $past(w[12] | w[11] | command_byte_cut); endproperty
    a_cut: assert property (p_cut) else $error("current cut wrong");
    property p_decay; $past(rstn) |-> drive_ctl.single_pulse_decay_sel == $past(w[9]); endproperty
    a_decay: assert property (p_decay) else $error("decay select wrong");
    property p_enc;
        $past(rstn && w[8] && internal_positioning && encoder_variant)
            |-> input_bytes_2_3 == $past(encoder_position[15:0]);
    endproperty
    a_enc: assert property (p_enc) else $error("encoder view wrong");
    property p_lag;
        $past(rstn && !w[8] && !w[5] && w[7] && internal_positioning)
            |-> input_bytes_2_3 == $past(position_error[15:0]);
    endproperty
    a_lag: assert property (p_lag) else $error("lag view wrong");
    property p_pos; $past(rstn && w[8:5] == 4'h0) |-> input_bytes_2_3 == $past(position[15:0]); endproperty
    a_pos: assert property (p_pos) else $error("position view wrong");
    property p_full; capture_count <= 5'h14; endproperty
    a_full: assert property (p_full) else $error("capture count too high");
    property p_idx;
        $past(rstn && w[4:0] == 5'h01) && w[0] && $rose(latch_pins.index_c) && $stable(w[6])
            && capture_array_enable && capture_count < 5'h14 |=> capture_count == $past(capture_count) + 5'h1;
    endproperty
    a_idx: assert property (p_idx) else $error("index capture missed");
    property p_prio;
        $past(rstn && w[4:0] == 5'h01, 2) && $past(w[4:0]) == 5'h03 && w[4:0] == 5'h03 && $stable(w[6])
            && $rose(latch_pins.digital_input_one) && !$rose(latch_pins.index_c) |=> $stable(capture_count);
    endproperty
    a_prio: assert property (p_prio) else $error("lower source captured");
    c_zero: cover property ($rose(w[13]));
    c_full: cover property (capture_count == 5'h14);
    c_adv: cover property ($changed(w[6]) && w[5]);
endmodule

bind stepper_control_word_decoder stepper_control_word_decoder_props chk (.clk, .rstn, .motion_control_word,
    .command_byte_cut, .preset_low_reg, .preset_high_reg, .capture_array_enable, .encoder_variant,
    .internal_positioning, .step_valid, .position_error, .encoder_position, .latch_pins, .position,
    .drive_ctl, .current_limit_en, .input_bytes_2_3, .capture_count);

/* File: bench/fieldbus_master_model.sv */
// Controller side: writes the control word of the output image.
// Assumes the bench hands it the fifteen defined bits.
`timescale 1ns/100ps

module fieldbus_master_model (
    // Bench side
    input  wire logic [14:0] cw_cmd,
    // Output image
    output logic [15:0]      motion_control_word
);
    assign motion_control_word = {1'b0, cw_cmd};
endmodule

/* File: bench/stepper_control_word_decoder_tb.sv */
// Bench for the control word decoder: queued expectations, watchdog.
// Assumes decoder, controller model and checker are compiled first.
`timescale 1ns/100ps

module stepper_control_word_decoder_tb;
    typedef struct packed { logic [2:0] s; logic [31:0] v; } note_t;
    logic                       clk, rstn, cut, stv, ena, enc_v, intp, cle, cv, lva;
    logic [14:0]                cw;
    logic [15:0]                mcw, plo, phi, ib;
    logic [31:0]                pv, dlt, perr, epos, pos, tpos, tvel, ep;
    logic [7:0]                 lvl, cl;
    logic [4:0]                 cnt;
    motion_cw_pkg::latch_pins_t pins;
    motion_cw_pkg::drive_ctl_t  dc;
    int                         n_errors, n_checks, seed, i, k;
    int                         bt[5] = '{0, 4, 3, 1, 2};
    int                         pn[5] = '{3, 2, 2, 1, 0};
    note_t                      q[$], n;
    logic [31:0]                cap[$];

    fieldbus_master_model ctl (.cw_cmd(cw), .motion_control_word(mcw));
    stepper_control_word_decoder uut (.clk(clk), .rstn(rstn), .motion_control_word(mcw), .command_byte_cut(cut),
        .process_value(pv), .preset_low_reg(plo), .preset_high_reg(phi), .reduced_current_level_reg(lvl),
        .capture_array_enable(ena), .encoder_variant(enc_v), .internal_positioning(intp), .step_delta(dlt),
        .step_valid(stv), .position_error(perr), .encoder_position(epos), .latch_pins(pins), .position(pos),
        .target_position(tpos), .target_velocity(tvel), .drive_ctl(dc), .current_limit(cl),
        .current_limit_en(cle), .input_bytes_2_3(ib), .capture_count(cnt), .capture_valid(cv),
        .latch_view_active(lva));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task t(input int c);
        repeat (c) begin
            @(posedge clk);
            #1;
        end
    endtask
    task ex(input logic [2:0] s, input logic [31:0] v);
        q.push_back({s, v});
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----
    // Scoreboard: notes land one edge after the driver files them
    // ----
    always @(negedge clk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            case (n.s)
                3'h0: chk(pos, n.v);
                3'h1: chk({16'h0000, ib}, n.v);
                3'h2: chk({27'h0, cnt}, n.v);
                3'h3: chk({19'h0, dc, cle, cl}, n.v);
                3'h4: chk(tpos, n.v);
                3'h5: chk(tvel, n.v);
                default: chk({30'h0, cv, lva}, n.v);
            endcase
        end
    end

    initial begin
        #(4 * 5000);
        n_errors++;
        tally_and_finish;
    end

    initial begin
        seed = 32'h12867B3D;
        {rstn, cw, cut, stv, pins} = '0;
        {ena, enc_v, intp} = 3'h7;
        {pv, dlt, perr, epos} = {$random(seed), $random(seed), $random(seed), $random(seed)};
        {plo, phi, lvl} = {$random(seed), $random(seed)};
        t(6);
        rstn = 1'b1;
        t(1);
        ex(0, 32'h0);
        ex(6, 32'h0);
        for (i = 0; i < 16; i++) begin
            cw = {i[0], 1'b0, i[1], i[2], 1'b0, i[3], 9'h000};
            {cut, pv, lvl} = {$random(seed), $random(seed)};
            t(1);
            ex(3, {cw[14], cw[12], cw[11] | cut, cw[9], cw[12] | cw[11] | cut, lvl});
            ex(cw[14] ? 3'h4 : 3'h5, pv);
        end
        cw = 15'h0000;
        t(1);
        cw = 15'h0400;
        t(1);
        ex(0, {phi, plo});
        cw = 15'h2400;
        t(1);
        ex(0, 32'h0);
        cw = 15'h2000;
        t(1);
        cw = 15'h2400;
        t(1);
        ex(0, 32'h0);
        cw = 15'h0400;
        t(1);
        ex(0, 32'h0);
        cw = 15'h0000;
        t(1);
        cw = 15'h0400;
        t(1);
        ex(0, {phi, plo});
        ep = {phi, plo};
        // Views: encoder or lag bit set alone, both need internal positioning
        for (i = 0; i < 4; i++) begin
            cw = {6'h00, i[0], ~i[0], 7'h00};
            intp = i[1];
            {perr, epos} = {$random(seed), $random(seed)};
            t(1);
            ex(1, !i[1] ? ep[15:0] : i[0] ? epos[15:0] : perr[15:0]);
        end
        for (k = 0; k < 5; k++) begin
            dlt = $random(seed);
            stv = 1'b1;
            t(1);
            stv = 1'b0;
            ep = ep + dlt;
            cw = 15'h0000;
            cw[bt[k]] = 1'b1;
            pins = (bt[k] == 4) ? 4'hF : 4'h0;
            t(3);
            pins[pn[k]] = ~pins[pn[k]];
            t(2);
            cap.push_back(ep);
            ex(2, k + 1);
        end
        cw = 15'h0001;
        pins = 4'h0;
        t(1);
        cw = 15'h0003;
        t(1);
        pins[1] = 1'b1;
        t(2);
        ex(2, 32'h5);
        pins[3] = 1'b1;
        t(2);
        cap.push_back(ep);
        ex(2, 32'h6);
        cw = 15'h0020;
        t(2);
        ex(1, cap[0][15:0]);
        ex(6, 32'h3);
        // Last toggle meets a single entry, which must stay
        for (i = 1; i < 7; i++) begin
            cw[6] = ~cw[6];
            t(2);
            ex(1, cap[(i < 6) ? i : 5][15:0]);
            ex(2, (i < 6) ? 6 - i : 1);
        end
        cw = 15'h0001;
        pins = 4'h0;
        t(3);
        for (i = 0; i < 22; i++) begin
            pins[3] = 1'b1;
            t(1);
            pins[3] = 1'b0;
            t(1);
        end
        ex(2, 32'h14);
        ex(6, 32'h2);
        t(2);
        tally_and_finish;
    end
endmodule
